// ===== hw/exec_pkg.sv
// Purpose: Constants for the move, branch, skip, table and miscellaneous execution unit.
// Assumes: Opcodes and register offsets here are local encodings of this unit.
// Notes: Cycle figures are instruction cycles of one aclk each.
// Summary of operation
// - Memory byte copied into working register in one cycle, flags untouched.
// - Working register written to memory byte in one cycle, flags untouched.
// - Immediate loaded into working register in one cycle, no flags.
// - Single bit 0..7 of memory byte cleared or set in one cycle.
// - Jump, call, return, literal return, interrupt return take two cycles, no flags.
// - Literal return pops address and loads immediate into working register.
// - Skip-when-zero-copy copies byte to working register and skips on zero.
// - Skip next instruction when whole memory byte is nonzero.
// - Bit-test skip skips when selected bit is zero.
// - Complementary bit-test skip skips when selected bit is one.
// - Increment or decrement and skip on zero result; result to memory or register.
// - Skip instructions take one cycle without skip, three when taken.
// - Any write of program counter low byte takes two cycles, three if the same instruction also skips.
// - Table fetch, given- or last-page form alike, ignores page; high to result register, low to memory.
// - Preincrement table fetch advances table pointer low first, then fetches.
// - Watchdog clear restarts watchdog and clears expiry and powerdown flags.
// - Power-down takes one cycle, enters power-down, updates both flags.
// - Nibble exchange swaps high and low nibbles to memory or working register.
package exec_pkg;

  // ==========================================================================
  // Register map of the AXI4-Lite slave
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_WREG = 8'h04;
  localparam logic [7:0] OFS_PC = 8'h08;
  localparam logic [7:0] OFS_TABLE_POINTER_LOW = 8'h0C;
  localparam logic [7:0] OFS_TABLE_RESULT_HIGH = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_CYCLES = 8'h18;
  localparam logic [7:0] OFS_MEM = 8'h80;
  localparam logic [7:0] OFS_ROM = 8'hC0;
  localparam int MEM_DEPTH = 16;
  localparam int ROM_DEPTH = 16;
  localparam int PCL_ADDR = 2;
  localparam int ST_TO = 0;
  localparam int ST_PDF = 1;
  localparam int ST_HALT = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_SKIP = 4;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_SKIP = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Instruction word: op [23:16], bit [15:13], page [12:8], operand [7:0]
  typedef enum logic [7:0]
  {
    OP_IDLE = 8'h00, OP_LOAD_W = 8'h01, OP_STORE_W = 8'h02, OP_LOAD_IMM = 8'h03,
    OP_BIT_CLR = 8'h04, OP_BIT_SET = 8'h05, OP_BRANCH = 8'h06, OP_CALL = 8'h07,
    OP_EXIT = 8'h08, OP_EXIT_LIT = 8'h09, OP_INT_EXIT = 8'h0A, OP_SZ = 8'h0B,
    OP_SZ_COPY = 8'h0C, OP_SNZ = 8'h0D, OP_SZ_BIT = 8'h0E, OP_SNZ_BIT = 8'h0F,
    OP_INC_SZ = 8'h10, OP_DEC_SZ = 8'h11, OP_INC_SZ_W = 8'h12, OP_DEC_SZ_W = 8'h13,
    OP_TFETCH = 8'h14, OP_TFETCH_LAST = 8'h15, OP_TFETCH_PRE = 8'h16,
    OP_TFETCH_PRE_LAST = 8'h17, OP_FORCE_ZERO = 8'h18, OP_FORCE_ONES = 8'h19,
    OP_WDT_CLEAR = 8'h1A, OP_NIBBLE = 8'h1B, OP_NIBBLE_W = 8'h1C, OP_POWERDOWN = 8'h1D
  } opcode_e;

endpackage

// ===== hw/exec_unit.sv
// Purpose: Executes move, bit, branch, skip, call/return, table and misc instructions.
// Assumes: Software posts one instruction word at a time over AXI4-Lite.
// Notes: Data memory and table program memory are small flip-flop arrays here.
`timescale 1ns/1ps
`default_nettype none

module exec_unit #(
  parameter int STACK_DEPTH = 4
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Watchdog and power control
  output logic watchdog_restart,
  output logic powerdown_mode
);

  // ==========================================================================
  // State
  typedef enum {S_IDLE, S_EXEC, S_WAIT} phase_e;
  phase_e phase_ff, nxt_phase;
  logic [7:0] mem_ff [exec_pkg::MEM_DEPTH];
  logic [7:0] nxt_mem [exec_pkg::MEM_DEPTH];
  logic [15:0] rom_ff [exec_pkg::ROM_DEPTH];
  logic [15:0] nxt_rom [exec_pkg::ROM_DEPTH];
  logic [23:0] instr_ff, nxt_instr;
  logic [7:0] working_register_ff, nxt_working_register;
  logic [12:0] pc_ff, nxt_pc;
  logic [12:0] stack_ff [STACK_DEPTH];
  logic [12:0] nxt_stack [STACK_DEPTH];
  logic [1:0] sp_ff, nxt_sp;
  logic [7:0] table_pointer_low_ff, nxt_table_pointer_low;
  logic [7:0] table_result_high_ff, nxt_table_result_high;
  logic watchdog_expiry_flag_ff, nxt_watchdog_expiry_flag;
  logic powerdown_flag_ff, nxt_powerdown_flag;
  logic halt_ff, nxt_halt;
  logic skip_ff, nxt_skip;
  logic [1:0] cnt_ff, nxt_cnt;
  logic [31:0] cycles_ff, nxt_cycles;
  logic wd_restart_ff, nxt_wd_restart;
  // Bus state
  logic aw_ff, nxt_aw, w_ff, nxt_w, bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [7:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;

  // ==========================================================================
  // Decode helpers
  exec_pkg::opcode_e op;
  logic [2:0] bsel;
  logic [3:0] ma;
  logic [7:0] mv, imm;
  assign op = exec_pkg::opcode_e'(instr_ff[23:16]);
  assign bsel = instr_ff[15:13];
  assign imm = instr_ff[7:0];
  assign ma = instr_ff[3:0];
  assign mv = mem_ff[ma];

  assign s_axi_awready = !aw_ff && !bvalid_ff;
  assign s_axi_wready = !w_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign watchdog_restart = wd_restart_ff;
  assign powerdown_mode = halt_ff;

  // ==========================================================================
  // Next state
  always_comb
  begin
    logic [7:0] res;
    logic [7:0] tp;
    logic [12:0] pc1;
    logic [1:0] len;
    logic wr_mem, sk, wr_pcl;
    logic [7:0] a;
    logic [31:0] d;
    logic go;
    res = exec_pkg::BYTE_ZERO;
    tp = table_pointer_low_ff;
    pc1 = pc_ff + 13'h1;
    len = exec_pkg::CYC_ONE;
    wr_mem = 1'b0;
    sk = 1'b0;
    wr_pcl = 1'b0;
    a = awaddr_ff;
    d = wdata_ff;
    go = 1'b0;
    nxt_phase = phase_ff;
    nxt_mem = mem_ff;
    nxt_rom = rom_ff;
    nxt_instr = instr_ff;
    nxt_working_register = working_register_ff;
    nxt_pc = pc_ff;
    nxt_stack = stack_ff;
    nxt_sp = sp_ff;
    nxt_table_pointer_low = table_pointer_low_ff;
    nxt_table_result_high = table_result_high_ff;
    nxt_watchdog_expiry_flag = watchdog_expiry_flag_ff;
    nxt_powerdown_flag = powerdown_flag_ff;
    nxt_halt = halt_ff;
    nxt_skip = skip_ff;
    nxt_cnt = cnt_ff;
    nxt_cycles = cycles_ff;
    nxt_wd_restart = 1'b0;
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    // Address and data may arrive in either order; each is latched alone.
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_aw = 1'b1;
      nxt_awaddr = s_axi_awaddr;
      a = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_w = 1'b1;
      nxt_wdata = s_axi_wdata;
      d = s_axi_wdata;
    end
    if (nxt_aw && nxt_w)
    begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = exec_pkg::RESP_OKAY;
      // Status and table memory writes are taken while one executes; all others are refused.
      if (a == exec_pkg::OFS_INSTR && phase_ff == S_IDLE && s_axi_wstrb[2:0] == 3'h7)
      begin
        nxt_instr = d[23:0];
        nxt_phase = S_EXEC;
      end
      else if (a == exec_pkg::OFS_WREG && phase_ff == S_IDLE)
        nxt_working_register = d[7:0];
      else if (a == exec_pkg::OFS_TABLE_POINTER_LOW && phase_ff == S_IDLE)
        nxt_table_pointer_low = d[7:0];
      else if (a == exec_pkg::OFS_PC && phase_ff == S_IDLE)
        nxt_pc = d[12:0];
      else if (a == exec_pkg::OFS_STATUS)
      begin
        // Writing zero to the power-down bit wakes the core.
        if (!d[exec_pkg::ST_HALT])
          nxt_halt = 1'b0;
      end
      else if (a[7:6] == exec_pkg::OFS_MEM[7:6] && {1'b0, a[5:2]} < 5'(exec_pkg::MEM_DEPTH)
        && phase_ff == S_IDLE)
        nxt_mem[a[5:2]] = d[7:0];
      else if (a[7:6] == exec_pkg::OFS_ROM[7:6] && {1'b0, a[5:2]} < 5'(exec_pkg::ROM_DEPTH))
        nxt_rom[a[5:2]] = d[15:0];
      else
        nxt_bresp = exec_pkg::RESP_SLVERR;
    end
    if (bvalid_ff && s_axi_bready)
      nxt_bvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp = exec_pkg::RESP_OKAY;
      nxt_rdata = 32'h0000_0000;
      case (s_axi_araddr)
        exec_pkg::OFS_INSTR: nxt_rdata = {8'h00, instr_ff};
        exec_pkg::OFS_WREG: nxt_rdata = {24'h000000, working_register_ff};
        exec_pkg::OFS_PC: nxt_rdata = {19'h00000, pc_ff};
        exec_pkg::OFS_TABLE_POINTER_LOW: nxt_rdata = {24'h000000, table_pointer_low_ff};
        exec_pkg::OFS_TABLE_RESULT_HIGH: nxt_rdata = {24'h000000, table_result_high_ff};
        exec_pkg::OFS_STATUS: nxt_rdata = {27'h0000000, skip_ff, phase_ff != S_IDLE, halt_ff,
          powerdown_flag_ff, watchdog_expiry_flag_ff};
        exec_pkg::OFS_CYCLES: nxt_rdata = cycles_ff;
        default:
        begin
          if (s_axi_araddr[7:6] == exec_pkg::OFS_MEM[7:6]
            && {1'b0, s_axi_araddr[5:2]} < 5'(exec_pkg::MEM_DEPTH))
            nxt_rdata = {24'h000000, mem_ff[s_axi_araddr[5:2]]};
          else if (s_axi_araddr[7:6] == exec_pkg::OFS_ROM[7:6])
            nxt_rdata = {16'h0000, rom_ff[s_axi_araddr[5:2]]};
          else
            nxt_rresp = exec_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_ff && s_axi_rready)
      nxt_rvalid = 1'b0;

    // Execution: all effects land in the first cycle, then the count runs out.
    case (phase_ff)
      S_IDLE: ;
      S_EXEC:
      begin
        go = 1'b1;
        nxt_pc = pc1;
        case (op)
          exec_pkg::OP_IDLE: ;
          exec_pkg::OP_LOAD_W: nxt_working_register = mv;
          exec_pkg::OP_STORE_W:
          begin
            res = working_register_ff;
            wr_mem = 1'b1;
          end
          exec_pkg::OP_LOAD_IMM: nxt_working_register = imm;
          exec_pkg::OP_BIT_CLR, exec_pkg::OP_BIT_SET:
          begin
            res = mv;
            res[bsel] = (op == exec_pkg::OP_BIT_SET);
            wr_mem = 1'b1;
          end
          exec_pkg::OP_BRANCH:
          begin
            nxt_pc = instr_ff[12:0];
            len = exec_pkg::CYC_TWO;
          end
          exec_pkg::OP_CALL:
          begin
            nxt_stack[sp_ff] = pc1;
            nxt_sp = sp_ff + 2'h1;
            nxt_pc = instr_ff[12:0];
            len = exec_pkg::CYC_TWO;
          end
          exec_pkg::OP_EXIT, exec_pkg::OP_EXIT_LIT, exec_pkg::OP_INT_EXIT:
          begin
            nxt_sp = sp_ff - 2'h1;
            nxt_pc = stack_ff[nxt_sp];
            len = exec_pkg::CYC_TWO;
            if (op == exec_pkg::OP_EXIT_LIT)
              nxt_working_register = imm;
          end
          exec_pkg::OP_SZ: sk = (mv == exec_pkg::BYTE_ZERO);
          exec_pkg::OP_SZ_COPY:
          begin
            nxt_working_register = mv;
            sk = (mv == exec_pkg::BYTE_ZERO);
          end
          exec_pkg::OP_SNZ: sk = (mv != exec_pkg::BYTE_ZERO);
          exec_pkg::OP_SZ_BIT: sk = !mv[bsel];
          exec_pkg::OP_SNZ_BIT: sk = mv[bsel];
          exec_pkg::OP_INC_SZ, exec_pkg::OP_DEC_SZ, exec_pkg::OP_INC_SZ_W, exec_pkg::OP_DEC_SZ_W:
          begin
            if (op == exec_pkg::OP_INC_SZ || op == exec_pkg::OP_INC_SZ_W)
              res = mv + 8'h01;
            else
              res = mv - 8'h01;
            sk = (res == exec_pkg::BYTE_ZERO);
            if (op == exec_pkg::OP_INC_SZ_W || op == exec_pkg::OP_DEC_SZ_W)
              nxt_working_register = res;
            else
              wr_mem = 1'b1;
          end
          exec_pkg::OP_TFETCH, exec_pkg::OP_TFETCH_LAST, exec_pkg::OP_TFETCH_PRE,
            exec_pkg::OP_TFETCH_PRE_LAST:
          begin
            if (op == exec_pkg::OP_TFETCH_PRE || op == exec_pkg::OP_TFETCH_PRE_LAST)
            begin
              tp = table_pointer_low_ff + 8'h01;
              nxt_table_pointer_low = tp;
            end
            // Page is ignored in this small table store; only pointer bits [3:0] shape the index.
            res = rom_ff[tp[3:0]][7:0];
            nxt_table_result_high = rom_ff[tp[3:0]][15:8];
            wr_mem = 1'b1;
            len = exec_pkg::CYC_TWO;
          end
          exec_pkg::OP_FORCE_ZERO, exec_pkg::OP_FORCE_ONES:
          begin
            res = exec_pkg::BYTE_ZERO;
            if (op == exec_pkg::OP_FORCE_ONES)
              res = exec_pkg::BYTE_ONES;
            wr_mem = 1'b1;
          end
          exec_pkg::OP_WDT_CLEAR:
          begin
            nxt_wd_restart = 1'b1;
            nxt_watchdog_expiry_flag = 1'b0;
            nxt_powerdown_flag = 1'b0;
          end
          exec_pkg::OP_NIBBLE:
          begin
            res = {mv[3:0], mv[7:4]};
            wr_mem = 1'b1;
          end
          exec_pkg::OP_NIBBLE_W: nxt_working_register = {mv[3:0], mv[7:4]};
          exec_pkg::OP_POWERDOWN:
          begin
            nxt_halt = 1'b1;
            nxt_watchdog_expiry_flag = 1'b0;
            nxt_powerdown_flag = 1'b1;
          end
          default: ;
        endcase
        if (wr_mem)
          nxt_mem[ma] = res;
        wr_pcl = wr_mem && ma == 4'(exec_pkg::PCL_ADDR);
        if (wr_pcl)
          nxt_pc = {pc_ff[12:8], res};
        if (sk)
        begin
          nxt_pc = pc_ff + 13'h2;
          len = exec_pkg::CYC_SKIP;
        end
        else if (wr_pcl)
          len = exec_pkg::CYC_TWO;
        nxt_skip = sk;
        nxt_cnt = len - 2'h1;
        nxt_phase = (len == exec_pkg::CYC_ONE) ? S_IDLE : S_WAIT;
      end
      S_WAIT:
      begin
        go = 1'b1;
        nxt_cnt = cnt_ff - 2'h1;
        if (cnt_ff == exec_pkg::CYC_ONE)
          nxt_phase = S_IDLE;
      end
      default: nxt_phase = S_IDLE;
    endcase
    if (go)
      nxt_cycles = cycles_ff + 32'h1;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_ff <= S_IDLE;
      for (int i = 0; i < exec_pkg::MEM_DEPTH; i++)
        mem_ff[i] <= exec_pkg::BYTE_ZERO;
      for (int i = 0; i < exec_pkg::ROM_DEPTH; i++)
        rom_ff[i] <= 16'h0000;
      for (int i = 0; i < STACK_DEPTH; i++)
        stack_ff[i] <= 13'h0000;
      instr_ff <= 24'h000000;
      working_register_ff <= exec_pkg::BYTE_ZERO;
      pc_ff <= 13'h0000;
      sp_ff <= 2'h0;
      table_pointer_low_ff <= exec_pkg::BYTE_ZERO;
      table_result_high_ff <= exec_pkg::BYTE_ZERO;
      watchdog_expiry_flag_ff <= 1'b0;
      powerdown_flag_ff <= 1'b0;
      halt_ff <= 1'b0;
      skip_ff <= 1'b0;
      cnt_ff <= 2'h0;
      cycles_ff <= 32'h0000_0000;
      wd_restart_ff <= 1'b0;
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      rdata_ff <= 32'h0000_0000;
      bresp_ff <= exec_pkg::RESP_OKAY;
      rresp_ff <= exec_pkg::RESP_OKAY;
    end
    else
    begin
      phase_ff <= nxt_phase;
      mem_ff <= nxt_mem;
      rom_ff <= nxt_rom;
      stack_ff <= nxt_stack;
      instr_ff <= nxt_instr;
      working_register_ff <= nxt_working_register;
      pc_ff <= nxt_pc;
      sp_ff <= nxt_sp;
      table_pointer_low_ff <= nxt_table_pointer_low;
      table_result_high_ff <= nxt_table_result_high;
      watchdog_expiry_flag_ff <= nxt_watchdog_expiry_flag;
      powerdown_flag_ff <= nxt_powerdown_flag;
      halt_ff <= nxt_halt;
      skip_ff <= nxt_skip;
      cnt_ff <= nxt_cnt;
      cycles_ff <= nxt_cycles;
      wd_restart_ff <= nxt_wd_restart;
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      bvalid_ff <= nxt_bvalid;
      rvalid_ff <= nxt_rvalid;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
      bresp_ff <= nxt_bresp;
      rresp_ff <= nxt_rresp;
    end
  end

endmodule

`default_nettype wire

// ===== tb/exec_unit_chk_asserts.sv
// Purpose: Bus handshake and control-output checks for exec_unit.
// Assumes: Sees only top-level ports; bus answers follow one cycle after the handshake.
// Notes: Bind statement follows the module.
`timescale 1ns/1ps
`default_nettype none

module exec_unit_chk #(
  parameter int STACK_DEPTH = 4
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write side
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read side
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Control outputs
  input wire logic watchdog_restart,
  input wire logic powerdown_mode
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================================
  // Register bus
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp not held");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("r not held");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar while r");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("aw or w while b");
  r_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read");
  b_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("late write response");
  // A hole in the map must answer with an error and no stale data.
  bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h18
    && s_axi_araddr < 8'h80 |=> s_axi_rresp == exec_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read");

  // ==========================================================================
  // Control outputs
  wd_pulse_a: assert property (watchdog_restart |=> !watchdog_restart)
    else $error("restart too long");
  pd_hold_a: assert property (powerdown_mode && !s_axi_awvalid && !s_axi_wvalid
    && !s_axi_bvalid |=> powerdown_mode) else $error("power-down lost");

  c_wd: cover property (watchdog_restart);
  c_pd: cover property ($rose(powerdown_mode));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == exec_pkg::RESP_SLVERR);
endmodule

bind exec_unit exec_unit_chk #(.STACK_DEPTH(STACK_DEPTH)) u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .watchdog_restart(watchdog_restart), .powerdown_mode(powerdown_mode));

`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for exec_unit over its register bus.
// Assumes: An instruction settles within four cycles of its write response.
// Notes: Expected cycles and flags are tracked here as a running model.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] m;} rexp_s;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, wd_rst, pd_mode;
  logic [7:0] awaddr, araddr, v, t, h;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, flg;
  rexp_s rq[$];
  rexp_s cur;
  logic [1:0] bq[$];
  int err_total, num_checks, tick, cyc_exp, pulses, p0;

  exec_unit #(.STACK_DEPTH(4)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .watchdog_restart(wd_rst), .powerdown_mode(pd_mode));

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ==========================================================================
  // Checking
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic chk_pin(input string n, input logic e, input logic g);
    chk_val(n, {31'h0, e}, {31'h0, g});
  endtask

  // Responses are matched in order, so a slave that answers out of turn shows up here.
  always @(posedge aclk)
  begin
    tick++;
    if (wd_rst === 1'b1)
      pulses++;
    if (bvalid === 1'b1 && bready && bq.size() > 0)
      chk_val("bresp", 32'(bq.pop_front()), 32'(bresp));
    if (rvalid === 1'b1 && rready && rq.size() > 0)
    begin
      cur = rq.pop_front();
      chk_val($sformatf("rdata %h", cur.a), cur.d & cur.m, rdata & cur.m);
      chk_val("rresp", (cur.a > 8'h18 && cur.a < 8'h80) ? 32'h2 : 32'h0, 32'(rresp));
    end
    if (tick > 20000)
    begin
      err_total++;
      give_verdict();
    end
  end

  // ==========================================================================
  // Bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    bq.push_back(er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1)
        awvalid <= 1'b0;
      if (wvalid && wready === 1'b1)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    rq.push_back('{a, e, m});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  task automatic mw(input int i, input logic [7:0] d);
    wr(8'(exec_pkg::OFS_MEM + 4 * i), {24'h0, d});
  endtask

  task automatic mr(input int i, input logic [7:0] d);
    rd(8'(exec_pkg::OFS_MEM + 4 * i), {24'h0, d});
  endtask

  // Runs one instruction, then checks the cycle total and the flags it must not disturb.
  task automatic exe(input exec_pkg::opcode_e op, input int n, input logic [4:0] a = 5'h0,
    input logic [2:0] b = 3'h0, input logic [7:0] x = 8'h00);
    logic sk;
    sk = op >= exec_pkg::OP_SZ && op <= exec_pkg::OP_DEC_SZ_W;
    wr(exec_pkg::OFS_INSTR, {8'h00, op, b, a, x | 8'(a)});
    cyc_exp += n;
    repeat (4) @(posedge aclk);
    rd(exec_pkg::OFS_CYCLES, cyc_exp);
    rd(exec_pkg::OFS_STATUS, {27'h0, n == 3, 2'h0, flg}, sk ? 32'h13 : 32'h3);
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    void'($urandom(34));
    {aresetn, awvalid, wvalid, bready, arvalid, rready} <= 6'h0;
    awaddr <= 8'h00;
    araddr <= 8'h00;
    wdata <= 32'h0;
    wstrb <= 4'hF;
    flg = 2'h0;
    v = 8'($urandom());
    t = 8'($urandom());
    h = 8'($urandom());
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(exec_pkg::OFS_STATUS, 32'h0);
    chk_pin("powerdown", 1'b0, pd_mode);
    rd(8'h40, 32'h0);
    wr(8'h44, 32'h1, exec_pkg::RESP_SLVERR);
    mw(5, v);
    exe(exec_pkg::OP_LOAD_W, 1, 5'h05);
    rd(exec_pkg::OFS_WREG, {24'h0, v});
    exe(exec_pkg::OP_LOAD_IMM, 1, 5'h00, 3'h0, t);
    exe(exec_pkg::OP_STORE_W, 1, 5'h06);
    mr(6, t);
    exe(exec_pkg::OP_STORE_W, 2, 5'(exec_pkg::PCL_ADDR));
    for (int i = 0; i < 8; i++)
    begin
      mw(7, v);
      exe(exec_pkg::OP_SZ_BIT, v[i] ? 1 : 3, 5'h07, 3'(i));
      exe(exec_pkg::OP_SNZ_BIT, v[i] ? 3 : 1, 5'h07, 3'(i));
      exe(exec_pkg::OP_BIT_SET, 1, 5'h07, 3'(i));
      mr(7, v | 8'(1 << i));
      exe(exec_pkg::OP_BIT_CLR, 1, 5'h07, 3'(i));
      mr(7, v & ~8'(1 << i));
    end
    exe(exec_pkg::OP_FORCE_ONES, 1, 5'h08);
    mr(8, 8'hFF);
    exe(exec_pkg::OP_FORCE_ZERO, 1, 5'h08);
    mr(8, 8'h00);
    mw(9, v | 8'h01);
    exe(exec_pkg::OP_SZ, 1, 5'h09);
    exe(exec_pkg::OP_SNZ, 3, 5'h09);
    exe(exec_pkg::OP_SZ_COPY, 1, 5'h09);
    rd(exec_pkg::OFS_WREG, {24'h0, v | 8'h01});
    mw(9, 8'h00);
    exe(exec_pkg::OP_SNZ, 1, 5'h09);
    exe(exec_pkg::OP_SZ, 3, 5'h09);
    exe(exec_pkg::OP_SZ_COPY, 3, 5'h09);
    rd(exec_pkg::OFS_WREG, 32'h0);
    mw(10, 8'hFF);
    exe(exec_pkg::OP_INC_SZ, 3, 5'h0A);
    exe(exec_pkg::OP_INC_SZ, 1, 5'h0A);
    exe(exec_pkg::OP_DEC_SZ, 3, 5'h0A);
    mr(10, 8'h00);
    mw(10, 8'hFF);
    exe(exec_pkg::OP_INC_SZ_W, 3, 5'h0A);
    rd(exec_pkg::OFS_WREG, 32'h0);
    exe(exec_pkg::OP_DEC_SZ_W, 1, 5'h0A);
    rd(exec_pkg::OFS_WREG, 32'hFE);
    mr(10, 8'hFF);
    mw(11, v);
    exe(exec_pkg::OP_NIBBLE_W, 1, 5'h0B);
    rd(exec_pkg::OFS_WREG, {24'h0, v[3:0], v[7:4]});
    exe(exec_pkg::OP_NIBBLE, 1, 5'h0B);
    mr(11, {v[3:0], v[7:4]});
    exe(exec_pkg::OP_BRANCH, 2, 5'h00, 3'h0, 8'h10);
    rd(exec_pkg::OFS_PC, 32'h10);
    exe(exec_pkg::OP_CALL, 2, 5'h00, 3'h0, 8'h20);
    exe(exec_pkg::OP_EXIT_LIT, 2, 5'h00, 3'h0, t);
    rd(exec_pkg::OFS_PC, 32'h11);
    exe(exec_pkg::OP_CALL, 2, 5'h00, 3'h0, 8'h30);
    exe(exec_pkg::OP_EXIT, 2);
    exe(exec_pkg::OP_CALL, 2, 5'h00, 3'h0, 8'h40);
    exe(exec_pkg::OP_INT_EXIT, 2);
    exe(exec_pkg::OP_IDLE, 1);
    rd(exec_pkg::OFS_WREG, {24'h0, t});
    wr(8'(exec_pkg::OFS_ROM + 12), {16'h0, h, v});
    wr(8'(exec_pkg::OFS_ROM + 16), {16'h0, v, h});
    wr(exec_pkg::OFS_TABLE_POINTER_LOW, 32'h3);
    exe(exec_pkg::OP_TFETCH, 2, 5'h0C);
    rd(exec_pkg::OFS_TABLE_RESULT_HIGH, {24'h0, h}, 32'hFF);
    mw(12, 8'h00);
    exe(exec_pkg::OP_TFETCH_LAST, 2, 5'h0C);
    mr(12, v);
    exe(exec_pkg::OP_TFETCH_PRE, 2, 5'h0C);
    rd(exec_pkg::OFS_TABLE_POINTER_LOW, 32'h4, 32'hFF);
    mr(12, h);
    exe(exec_pkg::OP_TFETCH_PRE_LAST, 2, 5'h0C);
    mr(12, 8'h00);
    flg = 2'h2;
    exe(exec_pkg::OP_POWERDOWN, 1);
    chk_pin("powerdown", 1'b1, pd_mode);
    wr(exec_pkg::OFS_STATUS, 32'h3);
    repeat (2) @(posedge aclk);
    chk_pin("powerdown", 1'b0, pd_mode);
    flg = 2'h0;
    p0 = pulses;
    exe(exec_pkg::OP_WDT_CLEAR, 1);
    chk_pin("restart", 1'b1, pulses == p0 + 1);
    give_verdict();
  end
endmodule

`default_nettype wire
